// ===== logic/fbwp_map.vh
// register offsets, field positions, reset values and constants of the flash write protection block
// assumes a 32-bit classic Wishbone slave with word-aligned registers
`ifndef FBWP_MAP_VH
`define FBWP_MAP_VH

// register byte addresses
`define FBWP_CTRL_ADDR      8'h00
`define FBWP_LOCK_ADDR      8'h04
`define FBWP_STAT_ADDR      8'h08
// control register fields
`define FBWP_CTRL_PGM_BIT   0
`define FBWP_CTRL_ERASE_BIT 1
`define FBWP_CTRL_HV_BIT    3
`define FBWP_CTRL_RESET     8'h00
// status register fields
`define FBWP_STAT_READ_BIT  0
`define FBWP_STAT_BYP_BIT   1
`define FBWP_STAT_WAIT_BIT  2
`define FBWP_STAT_HIT_BIT   3
// lock byte location and region bases
`define FBWP_LOCK_LOC       16'hFF80
`define FBWP_BASE_4K        16'hF000
`define FBWP_BASE_8K        16'hE000
`define FBWP_BASE_16K       16'hC000
`define FBWP_BASE_ALL       16'hA000
`define FBWP_LOCK_RESET     8'h00

`endif

// ===== logic/fbwp_top.v
// flash block write protection: lock byte latch, select/high-voltage interlock, wait handling
// assumes a classic Wishbone master on SYS_CLK; only the bypass pin is synchronised here
`include "fbwp_map.vh"
`timescale 1ns/1ps
`default_nettype none

module fbwp_top
(
	input  wire        SYS_CLK,      // bus clock, 40 MHz
	input  wire        SRST,         // synchronous reset, active high
	input  wire        CLK_EN,       // freezes all state while low
	input  wire [7:0]  WB_ADR_I,     // register byte address
	input  wire [31:0] WB_DAT_I,     // write data
	input  wire [3:0]  WB_SEL_I,     // byte lane selects
	input  wire        WB_WE_I,      // write enable
	input  wire        WB_CYC_I,     // bus cycle
	input  wire        WB_STB_I,     // strobe
	output reg  [31:0] WB_DAT_O,     // read data
	output wire        WB_ACK_O,     // acknowledge
	input  wire        MEM_RD,       // cpu read of the flash array, one cycle
	input  wire        MEM_WR,       // cpu write to the flash array, one cycle
	input  wire [15:0] MEM_ADDR,     // array address of that access
	input  wire [7:0]  MEM_RDATA,    // byte read from the array
	input  wire        BYPASS_HIGH_VOLTAGE, // bypass level on interrupt pin, async
	input  wire        WAIT_MODE,    // processor in wait, same clock
	output reg         PROGRAM_SELECT, // program operation selected
	output reg         ERASE_SELECT, // erase operation selected
	output reg         HIGH_VOLTAGE_ON, // high voltage enable bit
	output reg         PUMP_ON,      // charge pump running
	output reg         ACCESS_BLOCKED // last target hit a locked region
);

	// lock byte held after each read of its location while a select is set
	reg  [7:0]  write_lock_ranges;
	reg         lock_read;
	reg         target_seen;
	reg  [15:0] target_addr;
	reg         ack_q;
	reg         byp_meta;
	reg         byp_sync;
	reg         next_pgm;
	reg         next_erase;
	reg         next_hv;
	wire        wb_req;
	wire        wr_ctrl;
	wire        lock_hit;

	// true, with the bypass level low, when an address falls inside a region locked by the byte
	function prot_hit;
		input [15:0] adr;
		input [7:0]  lck;
		input        byp;
		begin
			prot_hit = 1'b0;
			if (!byp)
			begin
				if (lck[3] && adr >= `FBWP_BASE_4K)
					prot_hit = 1'b1;
				if (lck[2] && adr >= `FBWP_BASE_8K)
					prot_hit = 1'b1;
				if (lck[1] && adr >= `FBWP_BASE_16K)
					prot_hit = 1'b1;
				if (lck[0] && adr >= `FBWP_BASE_ALL)
					prot_hit = 1'b1;
				// the lock byte itself needs the bypass level
				if (adr == `FBWP_LOCK_LOC)
					prot_hit = 1'b1;
			end
		end
	endfunction

	// two-stage synchroniser for the bypass pin
	always @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			byp_meta <= 1'b0;
			byp_sync <= 1'b0;
		end
		else if (CLK_EN)
		begin
			byp_meta <= BYPASS_HIGH_VOLTAGE;
			byp_sync <= byp_meta;
		end
	end

	// bus decode, single cycle ack
	assign wb_req   = WB_CYC_I & WB_STB_I & ~ack_q;
	assign WB_ACK_O = ack_q;
	assign wr_ctrl  = wb_req & CLK_EN & WB_WE_I & WB_SEL_I[0] &
		(WB_ADR_I == `FBWP_CTRL_ADDR);
	// check only against the byte read in this sequence; all-zero byte leaves all but the lock byte location open
	assign lock_hit = target_seen & lock_read &
		prot_hit(target_addr, write_lock_ranges, byp_sync);

	always @(posedge SYS_CLK)
	begin
		if (SRST)
			ack_q <= 1'b0;
		else if (CLK_EN)
			ack_q <= wb_req;
	end

	// read data register
	always @(posedge SYS_CLK)
	begin
		if (SRST)
			WB_DAT_O <= 32'h00000000;
		else if (CLK_EN && wb_req)
		begin
			case (WB_ADR_I)
				`FBWP_CTRL_ADDR:
					WB_DAT_O <= {28'h0000000, HIGH_VOLTAGE_ON, 1'b0, ERASE_SELECT, PROGRAM_SELECT};
				`FBWP_LOCK_ADDR:
					WB_DAT_O <= {24'h000000, write_lock_ranges};
				`FBWP_STAT_ADDR:
					WB_DAT_O <= {28'h0000000, ACCESS_BLOCKED, WAIT_MODE, byp_sync, lock_read};
				default:
					WB_DAT_O <= 32'h00000000;
			endcase
		end
	end

	// lock byte capture and sequence tracking
	always @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			write_lock_ranges <= `FBWP_LOCK_RESET;
			lock_read         <= 1'b0;
			target_seen       <= 1'b0;
			target_addr       <= 16'h0000;
		end
		else if (CLK_EN)
		begin
			if (!PROGRAM_SELECT && !ERASE_SELECT)
			begin
				// a new sequence starts with no read seen
				lock_read   <= 1'b0;
				target_seen <= 1'b0;
			end
			else
			begin
				if (MEM_RD && MEM_ADDR == `FBWP_LOCK_LOC)
				begin
					write_lock_ranges <= MEM_RDATA;
					lock_read         <= 1'b1;
				end
				if (MEM_WR && !HIGH_VOLTAGE_ON)
				begin
					target_addr <= MEM_ADDR;
					target_seen <= 1'b1;
				end
			end
		end
	end

	// select and high-voltage interlock
	always @*
	begin
		next_pgm   = PROGRAM_SELECT;
		next_erase = ERASE_SELECT;
		next_hv    = HIGH_VOLTAGE_ON;
		if (WAIT_MODE && HIGH_VOLTAGE_ON)
		begin
			// bits frozen while in wait with high voltage on
			next_pgm   = PROGRAM_SELECT;
		end
		else if (wr_ctrl)
		begin
			next_pgm   = WB_DAT_I[`FBWP_CTRL_PGM_BIT] & ~WB_DAT_I[`FBWP_CTRL_ERASE_BIT];
			next_erase = WB_DAT_I[`FBWP_CTRL_ERASE_BIT] & ~WB_DAT_I[`FBWP_CTRL_PGM_BIT];
			// set only with a select and a lock byte read
			next_hv    = WB_DAT_I[`FBWP_CTRL_HV_BIT] & (PROGRAM_SELECT | ERASE_SELECT) &
				lock_read & ~lock_hit;
			if (!WB_DAT_I[`FBWP_CTRL_HV_BIT])
				next_hv = 1'b0;
		end
		if (lock_hit && !HIGH_VOLTAGE_ON)
		begin
			next_pgm   = 1'b0;
			next_erase = 1'b0;
			next_hv    = 1'b0;
		end
	end

	always @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			PROGRAM_SELECT  <= 1'b0;
			ERASE_SELECT    <= 1'b0;
			HIGH_VOLTAGE_ON <= 1'b0;
			PUMP_ON         <= 1'b0;
			ACCESS_BLOCKED  <= 1'b0;
		end
		else if (CLK_EN)
		begin
			PROGRAM_SELECT  <= next_pgm;
			ERASE_SELECT    <= next_erase;
			HIGH_VOLTAGE_ON <= next_hv;
			// pump off in wait; read mode is untouched
			PUMP_ON         <= next_hv & ~WAIT_MODE;
			if (lock_hit)
				ACCESS_BLOCKED <= 1'b1;
			else if (wr_ctrl && (WB_DAT_I[`FBWP_CTRL_PGM_BIT] || WB_DAT_I[`FBWP_CTRL_ERASE_BIT]))
				ACCESS_BLOCKED <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ===== dv/fbwp_monitor.sv
// checker on the protection block ports
// assumes one clock domain, bound to fbwp_top
`timescale 1ns/1ps
`default_nettype none
module fbwp_monitor
(
	input wire logic SYS_CLK,         // clock
	input wire logic SRST,            // reset
	input wire logic WB_CYC_I,        // cycle
	input wire logic WB_STB_I,        // strobe
	input wire logic WB_ACK_O,        // ack
	input wire logic WAIT_MODE,       // wait
	input wire logic PROGRAM_SELECT,  // program
	input wire logic ERASE_SELECT,    // erase
	input wire logic HIGH_VOLTAGE_ON, // high voltage
	input wire logic PUMP_ON,         // pump
	input wire logic ACCESS_BLOCKED   // blocked
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SRST);
	// bus answer and select interlocks
	AST_ACK_NEXT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("request not answered");
	AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	AST_SEL_EXCL: assert property (!(PROGRAM_SELECT && ERASE_SELECT))
		else $error("both selects set");
	AST_HV_SEL: assert property (HIGH_VOLTAGE_ON |-> PROGRAM_SELECT || ERASE_SELECT)
		else $error("high voltage without select");
	AST_HV_RISE: assert property ($rose(HIGH_VOLTAGE_ON) |-> WB_ACK_O && !ACCESS_BLOCKED)
		else $error("high voltage rose wrongly");
	AST_BLOCK: assert property ($rose(ACCESS_BLOCKED) |-> ##[0:1] !(PROGRAM_SELECT || ERASE_SELECT))
		else $error("blocked target kept select");
	// pump follows high voltage outside wait
	AST_PUMP: assert property (!$past(SRST) |-> PUMP_ON == (HIGH_VOLTAGE_ON && !$past(WAIT_MODE)))
		else $error("pump mismatch");
	AST_WAIT_HOLD: assert property (WAIT_MODE && HIGH_VOLTAGE_ON |=> $stable({PROGRAM_SELECT, ERASE_SELECT, HIGH_VOLTAGE_ON}))
		else $error("state moved in wait");
	cover property ($rose(HIGH_VOLTAGE_ON));
	cover property ($rose(ACCESS_BLOCKED));
	cover property (WAIT_MODE && HIGH_VOLTAGE_ON);
endmodule
bind fbwp_top fbwp_monitor u_mon (.SYS_CLK(SYS_CLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WAIT_MODE(WAIT_MODE),
	.PROGRAM_SELECT(PROGRAM_SELECT), .ERASE_SELECT(ERASE_SELECT),
	.HIGH_VOLTAGE_ON(HIGH_VOLTAGE_ON), .PUMP_ON(PUMP_ON), .ACCESS_BLOCKED(ACCESS_BLOCKED));
`default_nettype wire

// ===== dv/fbwp_flash.sv
// flash array read model
// assumes the block samples the byte in the read cycle
`timescale 1ns/1ps
`default_nettype none
module fbwp_flash
(
	input  wire logic        MEM_RD,   // read pulse
	input  wire logic [15:0] MEM_ADDR, // read address
	input  wire logic [7:0]  lock,     // stored lock byte
	output logic      [7:0]  MEM_RDATA // read byte
);
	// lock byte at its fixed place, idle bus inverted
	wire logic [7:0] val = (MEM_ADDR == 16'hFF80) ? lock : MEM_ADDR[7:0];
	assign MEM_RDATA = MEM_RD ? val : ~val;
endmodule
`default_nettype wire

// ===== dv/fbwp_top_tb.sv
// bench for the flash write protection block
// assumes 40 MHz clock and the flash read model
`timescale 1ns/1ps
`default_nettype none
module fbwp_top_tb;
	logic clk = 0, rst = 1, cyc = 0, we = 0, rd = 0, wr = 0, byp = 0, wt = 0;
	logic [7:0]  adr = 8'h00, lk = 8'h00;
	logic [15:0] ma = 16'h0000, base[4] = '{16'hA000, 16'hC000, 16'hE000, 16'hF000};
	logic [31:0] wd = 32'h0, q_exp[$], e;
	logic [3:0]  sl = 4'h0;
	wire logic [31:0] rdat;
	wire logic [7:0]  mem;
	wire logic        ack;
	int bad_count = 0, checked = 0, i;
	fbwp_top DUT (.SYS_CLK(clk), .SRST(rst), .CLK_EN(1'b1), .WB_ADR_I(adr), .WB_DAT_I(wd),
		.WB_SEL_I(sl), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .MEM_RD(rd), .MEM_WR(wr), .MEM_ADDR(ma), .MEM_RDATA(mem),
		.BYPASS_HIGH_VOLTAGE(byp), .WAIT_MODE(wt), .PROGRAM_SELECT(), .ERASE_SELECT(),
		.HIGH_VOLTAGE_ON(), .PUMP_ON(), .ACCESS_BLOCKED());
	fbwp_flash u_flash (.MEM_RD(rd), .MEM_ADDR(ma), .lock(lk), .MEM_RDATA(mem));
	// clock
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	// one wishbone cycle, read expectation queued
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		if (!w)
			q_exp.push_back(d);
		cyc <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		sl <= 4'hF;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		cyc <= 0;
		@(posedge clk);
	endtask
	// one cpu array access
	task automatic pulse(input logic r, input logic [15:0] a);
		rd <= r;
		wr <= !r;
		ma <= a;
		@(posedge clk);
		rd <= 0;
		wr <= 0;
		@(posedge clk);
	endtask
	// full select, lock read, target, high voltage sequence
	task automatic prot(input logic [7:0] lock, input logic [15:0] t, input logic [1:0] s,
		input logic b, input logic r);
		logic blk;
		blk = r && !b && (t == 16'hFF80 || (lock[3] && t >= 16'hF000) || (lock[2] && t >= 16'hE000)
			|| (lock[1] && t >= 16'hC000) || lock[0]);
		lk <= lock;
		byp <= b;
		repeat (3) @(posedge clk);
		bus(1, 8'h00, {30'h0, s});
		if (r)
			pulse(1, 16'hFF80);
		if (r)
			bus(0, 8'h04, {24'h0, lock});
		pulse(0, t);
		bus(0, 8'h00, blk ? 32'h0 : {30'h0, s});
		bus(0, 8'h08, {28'h0, blk, 1'b0, b, r && !blk});
		bus(1, 8'h00, 32'h8 | s);
		bus(0, 8'h00, (r && !blk) ? 32'h8 | s : {30'h0, s});
		if (!blk && r)
		begin
			wt <= 1;
			bus(1, 8'h00, 32'h0);
			bus(0, 8'h00, 32'h8 | s);
			rst <= 1;
			@(posedge clk);
			rst <= 0;
			wt <= 0;
			bus(0, 8'h00, 32'h0);
		end
		bus(1, 8'h00, 32'h0);
		$display("sequence lock %0h target %0h done", lock, t);
	endtask
	// compare read answers with oldest expectation
	always @(posedge clk)
		if (ack === 1'b1 && !we)
		begin
			e = q_exp.pop_front();
			checked++;
			if (rdat !== e)
			begin
				$display("CHECK FAILED reg %0h exp %0h got %0h", adr, e, rdat);
				bad_count++;
			end
		end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// watchdog
	initial
	begin
		#200000;
		bad_count++;
		end_sim;
	end
	// main sequence
	initial
	begin
		i = $urandom(93);
		repeat (6) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		bus(0, 8'h08, 32'h0);
		bus(1, 8'h04, 32'hFF);
		bus(0, 8'h04, 32'h0);
		bus(0, 8'h0C, 32'h0);
		prot(8'h00, 16'hFF7F, 1, 0, 1);
		prot(8'h06, 16'hC000, 2, 0, 1);
		prot(8'h00, 16'hFF80, 1, 0, 1);
		prot(8'hFF, 16'hFF80, 2, 1, 1);
		prot(8'h00, 16'hA000, 1, 0, 0);
		for (i = 0; i < 4; i++)
		begin
			prot(8'h01 << i, base[i], 2, 0, 1);
			if (i > 0)
				prot(8'h01 << i, base[i] - 16'h1, 1, 0, 1);
		end
		repeat (10) prot(8'($urandom), 16'hA000 + 16'($urandom % 24576), 2'(1 + $urandom % 2),
			1'($urandom % 2), 1);
		end_sim;
	end
endmodule
`default_nettype wire
